/* shared/dmb_pkg.sv */
`default_nettype none
package dmb_pkg;
  // ************************************************************
  // address space geometry
  // ************************************************************
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int OFF_W     = 8;
  localparam int BANK_W    = 4;
  localparam int NUM_BANKS = 16;
  localparam int BANK_SIZE = 256;
  localparam int IMPL_BANKS = 4;
  localparam int SLOT_W    = 2;
  localparam int RAM_DEPTH = IMPL_BANKS * BANK_SIZE;

  // implemented banks: 0, 1, 2 and the register bank 15
  localparam logic [NUM_BANKS-1:0] IMPL_MASK = 16'h8007;

  // ************************************************************
  // access bank map and fixed locations
  // ************************************************************
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [OFF_W-1:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [ADDR_W-1:0] BANK_PTR_ADDR  = 12'hfe0;
  localparam logic [ADDR_W-1:0] PCL_ADDR       = 12'hff9;
  localparam logic [ADDR_W-1:0] ADDR_NONE      = 12'h000;

  // ************************************************************
  // bank pointer and instruction word fields
  // ************************************************************
  localparam logic [DATA_W-1:0] BANK_PTR_RESET = 8'h00;
  localparam logic [3:0]        BANK_PTR_UPPER = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_BYTE      = 8'h00;
  localparam logic [3:0]        WORD2_TAG      = 4'hf;
  localparam int                TAG_LSB        = 12;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} dmb_phase_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_FILE, OP_LOAD_BANK, OP_MOVE_FULL, OP_WORD2
  } dmb_op_t;
endpackage : dmb_pkg
`default_nettype wire

/* src/dmb_bank_ram.sv */
`timescale 1ns/10ps
`default_nettype none
module dmb_bank_ram (
  input  wire logic                       clk,
  input  wire logic [dmb_pkg::ADDR_W-1:0] addr,
  input  wire logic                       wr_en,
  input  wire logic [dmb_pkg::DATA_W-1:0] wr_data,
  output logic      [dmb_pkg::DATA_W-1:0] rd_data,
  output logic                            present
);
  import dmb_pkg::*;

  // ************************************************************
  // bank to storage slot
  // ************************************************************
  // slot counts implemented banks below the addressed one
  function automatic logic [SLOT_W-1:0] slot_of(input logic [BANK_W-1:0] bank);
    logic [SLOT_W-1:0] s;
    s = '0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (i < int'(bank) && IMPL_MASK[i]) s = s + 1'b1;
    end
    return s;
  endfunction : slot_of

  logic [DATA_W-1:0] mem [RAM_DEPTH];
  wire  [BANK_W-1:0] bank = addr[ADDR_W-1:OFF_W];
  wire  [SLOT_W+OFF_W-1:0] idx = {slot_of(bank), addr[OFF_W-1:0]};

  // absent banks swallow writes and read back zero
  assign present = IMPL_MASK[bank];
  assign rd_data = present ? mem[idx] : ZERO_BYTE;

  // no reset: contents survive every reset
  always_ff @(posedge clk) begin
    if (wr_en && present) mem[idx] <= wr_data;
  end
endmodule : dmb_bank_ram
`default_nettype wire

/* src/dmb_data_addr.sv */
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - data addresses are 12 bits wide, covering 4096 byte locations
// - sixteen banks of 256 bytes exist; only four are built
// - reading any unimplemented location returns zero
// - banked address is bank pointer on top, operand byte below
// - bank pointer keeps four low bits; upper four read zero
// - load-bank-literal puts its literal straight into the bank pointer
// - writes to absent banks are dropped, reads from them give zero
// - status flags update on absent-bank accesses as if successful
// - full-address move uses both 12-bit addresses, ignores bank pointer
// - every other instruction resolves its byte via pointer or access map
// - access map: 00h-5Fh hit bank 0, 60h-FFh hit bank 15
// - access-select one: address from bank pointer and offset
// - access-select zero: access map, bank pointer ignored
// - access map accesses finish in one instruction cycle
// - offset F9h with pointer 0Fh writes the program counter low byte
// - extended set enabled swaps the low access map for indexed
// - a lone second word with top nibble 1111 is a no-op
// - operand read in the second quarter, write in the fourth
// - general purpose RAM is never cleared by any reset
module dmb_data_addr (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire dmb_pkg::dmb_op_t           instr_op,
  input  wire logic [15:0]                instr_word,
  input  wire logic                       access_sel,
  input  wire logic                       dest_write,
  input  wire logic [dmb_pkg::DATA_W-1:0] result_data,
  input  wire logic                       extended_set_enable,
  input  wire logic [dmb_pkg::ADDR_W-1:0] index_base,
  output var dmb_pkg::dmb_phase_t         phase,
  output logic      [dmb_pkg::ADDR_W-1:0] data_addr,
  output logic                            addr_absent,
  output logic      [dmb_pkg::DATA_W-1:0] operand_data,
  output logic                            status_update,
  output logic      [dmb_pkg::DATA_W-1:0] bank_pointer,
  output logic                            pc_low_write,
  output logic      [dmb_pkg::DATA_W-1:0] pc_low_data,
  output logic                            word2_nop
);
  import dmb_pkg::*;

  // ************************************************************
  // instruction latched at the first quarter
  // ************************************************************
  dmb_op_t          cur_op;
  logic [3:0]       cur_lit;
  logic             cur_read;
  logic             cur_write;
  logic             pending_move;
  dmb_phase_t       next_phase;

  // ************************************************************
  // address formation from the incoming word
  // ************************************************************
  wire [OFF_W-1:0]  in_off     = instr_word[OFF_W-1:0];
  wire              low_half   = in_off < ACCESS_SPLIT;
  wire [ADDR_W-1:0] std_access = low_half ? {ACCESS_LO_BANK, in_off}
                                          : {ACCESS_HI_BANK, in_off};
  wire [ADDR_W-1:0] idx_access = index_base + {4'h0, in_off};
  // extended set reroutes only the low part of the map
  wire [ADDR_W-1:0] access_addr = (extended_set_enable && low_half)
                                  ? idx_access : std_access;
  wire [ADDR_W-1:0] banked_addr = {bank_pointer[BANK_W-1:0], in_off};
  // a=1 uses the pointer, a=0 forces the map and ignores it
  wire [ADDR_W-1:0] file_addr = access_sel ? banked_addr : access_addr;
  wire [ADDR_W-1:0] full_addr = instr_word[ADDR_W-1:0];
  wire              tag_ok    = instr_word[15:TAG_LSB] == WORD2_TAG;
  // second word only acts right after its own first word
  wire              word2_live = (instr_op == OP_WORD2) && tag_ok && pending_move;

  logic [ADDR_W-1:0] next_addr;
  logic              next_read;
  logic              next_write;

  // per-op address and access kind, all ops of the core set
  always_comb begin
    next_addr  = ADDR_NONE;
    next_read  = 1'b0;
    next_write = 1'b0;
    case (instr_op)
      OP_FILE: begin
        next_addr  = file_addr;
        next_read  = 1'b1;
        next_write = dest_write;
      end
      OP_MOVE_FULL: begin
        next_addr = full_addr;
        next_read = 1'b1;
      end
      OP_WORD2: begin
        next_addr  = word2_live ? full_addr : ADDR_NONE;
        next_write = word2_live;
      end
      default: begin
        next_addr = ADDR_NONE;
      end
    endcase
  end

  // ************************************************************
  // quarter-cycle sequencer
  // ************************************************************
  // one instruction cycle is four clk edges, Q1 through Q4
  always_comb begin
    case (phase)
      PH_Q1:   next_phase = PH_Q2;
      PH_Q2:   next_phase = PH_Q3;
      PH_Q3:   next_phase = PH_Q4;
      PH_Q4:   next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) phase <= PH_Q1;
    else         phase <= next_phase;
  end

  // ************************************************************
  // decode latch
  // ************************************************************
  // address settles in Q1 so a single cycle is enough
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_op    <= OP_NONE;
      cur_lit   <= 4'h0;
      cur_read  <= 1'b0;
      cur_write <= 1'b0;
      data_addr <= ADDR_NONE;
    end else if (phase == PH_Q1) begin
      cur_op    <= instr_op;
      cur_lit   <= instr_word[BANK_W-1:0];
      cur_read  <= next_read;
      cur_write <= next_write;
      data_addr <= next_addr;
    end
  end

  // ************************************************************
  // storage and read path
  // ************************************************************
  wire               is_bank_ptr = data_addr == BANK_PTR_ADDR;
  wire               is_pcl      = data_addr == PCL_ADDR;
  wire               do_write    = (phase == PH_Q4) && cur_write;
  // a move's second word writes the byte its first word fetched
  wire [DATA_W-1:0]  wr_byte = (cur_op == OP_WORD2) ? operand_data : result_data;
  wire               ram_we  = do_write && !is_bank_ptr;
  wire [DATA_W-1:0]  ram_rd;
  wire               ram_present;
  wire [DATA_W-1:0]  rd_byte = is_bank_ptr ? bank_pointer : ram_rd;

  dmb_bank_ram u_ram (
    .clk     (clk),
    .addr    (data_addr),
    .wr_en   (ram_we),
    .wr_data (wr_byte),
    .rd_data (ram_rd),
    .present (ram_present)
  );

  assign addr_absent = !ram_present;

  // operand fetched in Q2; absent banks come back as zero
  always_ff @(posedge clk) begin
    if (sys_rst) operand_data <= ZERO_BYTE;
    else if (phase == PH_Q2 && cur_read) operand_data <= rd_byte;
  end

  // ************************************************************
  // bank pointer
  // ************************************************************
  // upper nibble is hard zero, so a full-byte write cannot set it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_pointer <= BANK_PTR_RESET;
    end else if (phase == PH_Q4 && cur_op == OP_LOAD_BANK) begin
      bank_pointer <= {BANK_PTR_UPPER, cur_lit};
    end else if (do_write && is_bank_ptr) begin
      bank_pointer <= {BANK_PTR_UPPER, wr_byte[BANK_W-1:0]};
    end
  end

  // ************************************************************
  // move pairing and lone second word
  // ************************************************************
  // cleared by whatever ends the next cycle, so only the word
  // straight after the first word can use it
  always_ff @(posedge clk) begin
    if (sys_rst)               pending_move <= 1'b0;
    else if (phase == PH_Q4)   pending_move <= cur_op == OP_MOVE_FULL;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) word2_nop <= 1'b0;
    else word2_nop <= (phase == PH_Q1) && (instr_op == OP_WORD2) && !word2_live;
  end

  // ************************************************************
  // status flag strobe and program counter low byte
  // ************************************************************
  // flags follow the operation even when the bank is absent
  always_ff @(posedge clk) begin
    if (sys_rst) status_update <= 1'b0;
    else         status_update <= (phase == PH_Q4) && (cur_op == OP_FILE);
  end

  // writes here redirect the program counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_low_write <= 1'b0;
      pc_low_data  <= ZERO_BYTE;
    end else begin
      pc_low_write <= do_write && is_pcl;
      if (do_write && is_pcl) pc_low_data <= wr_byte;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_phase_order: assert property (
    phase == PH_Q1 |=> phase == PH_Q2 ##1 phase == PH_Q3 ##1 phase == PH_Q4)
    else $error("quarter phases out of order");
  a_bank_upper_zero: assert property (
    bank_pointer[DATA_W-1:BANK_W] == BANK_PTR_UPPER)
    else $error("bank pointer upper nibble not zero");
  a_load_bank_lit: assert property (
    phase == PH_Q1 && instr_op == OP_LOAD_BANK
    |=> ##3 bank_pointer == {BANK_PTR_UPPER, $past(instr_word[3:0], 4)})
    else $error("literal not loaded into bank pointer");
  a_banked_addr: assert property (
    phase == PH_Q1 && instr_op == OP_FILE && access_sel
    |=> data_addr == {$past(bank_pointer[3:0]), $past(instr_word[7:0])})
    else $error("banked address wrong");
  a_access_low_map: assert property (
    phase == PH_Q1 && instr_op == OP_FILE && !access_sel
    && !extended_set_enable && instr_word[7:0] < ACCESS_SPLIT
    |=> data_addr == {ACCESS_LO_BANK, $past(instr_word[7:0])})
    else $error("access map low part wrong");
  a_access_high_map: assert property (
    phase == PH_Q1 && instr_op == OP_FILE && !access_sel
    && instr_word[7:0] >= ACCESS_SPLIT
    |=> data_addr == {ACCESS_HI_BANK, $past(instr_word[7:0])})
    else $error("access map high part wrong");
  a_move_full_addr: assert property (
    phase == PH_Q1 && instr_op == OP_MOVE_FULL
    |=> data_addr == $past(instr_word[11:0]))
    else $error("full address not used");
  a_absent_read_zero: assert property (
    phase == PH_Q2 && cur_read && addr_absent |=> operand_data == ZERO_BYTE)
    else $error("absent bank read not zero");
  a_status_absent: assert property (
    phase == PH_Q4 && cur_op == OP_FILE |=> status_update)
    else $error("status strobe missing");
  a_lone_word_nop: assert property (
    phase == PH_Q1 && instr_op == OP_WORD2 && !pending_move
    |=> word2_nop ##0 (!ram_we) [*4])
    else $error("lone second word not a no-op");
  a_pcl_redirect: assert property (
    do_write && is_pcl |=> pc_low_write && pc_low_data == $past(wr_byte))
    else $error("program counter low byte not written");

  c_banked_write: cover property (phase == PH_Q4 && do_write && cur_op == OP_FILE);
  c_move_pair: cover property (phase == PH_Q4 && do_write && cur_op == OP_WORD2);
  c_absent_access: cover property (phase == PH_Q2 && cur_read && addr_absent);
  c_lone_word: cover property (word2_nop);
endmodule : dmb_data_addr
`default_nettype wire

/* tb/dmb_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// core decode side: feeds one instruction per instruction cycle
// ************************************************************
module dmb_core_model (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire dmb_pkg::dmb_phase_t phase,
  input  wire dmb_pkg::dmb_op_t    next_op,
  input  wire logic [15:0]         next_word,
  input  wire logic                next_a,
  input  wire logic                next_dw,
  input  wire logic [7:0]          next_res,
  output var dmb_pkg::dmb_op_t     instr_op,
  output logic      [15:0]         instr_word,
  output logic                     access_sel,
  output logic                     dest_write,
  output logic      [7:0]          result_data
);
  import dmb_pkg::*;
  // load on the q4 edge so the word stands from q1 to q4;
  // result_data is only wanted in q4, so it rides along with its word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_op    <= OP_NONE;
      instr_word  <= 16'h0000;
      access_sel  <= 1'b0;
      dest_write  <= 1'b0;
      result_data <= 8'h00;
    end else if (phase == PH_Q4) begin
      instr_op    <= next_op;
      instr_word  <= next_word;
      access_sel  <= next_a;
      dest_write  <= next_dw;
      result_data <= next_res;
    end
  end
endmodule : dmb_core_model
`default_nettype wire

/* tb/dmb_data_addr_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module dmb_data_addr_tb_top;
  import dmb_pkg::*;
  // ************************************************************
  // stimulus rows and bench signals
  // ************************************************************
  typedef struct packed {
    dmb_op_t     op;
    logic [15:0] w;
    logic        a, dw;
    logic [7:0]  res;
    logic [11:0] addr;
    logic        absent;
    logic [7:0]  rd;
    logic        chk;
    logic [7:0]  bp;
  } dmb_row_t;
  logic        clk, sys_rst, extended_set_enable, next_a, next_dw;
  logic        access_sel, dest_write, addr_absent, status_update;
  logic        pc_low_write, word2_nop;
  logic [11:0] index_base, data_addr;
  logic [15:0] next_word, instr_word;
  logic [7:0]  next_res, result_data, operand_data, bank_pointer, pc_low_data;
  dmb_op_t     next_op, instr_op;
  dmb_phase_t  phase;
  int          err_total = 0;
  int          tests_run = 0;
  // writes come before the reads that expect them: ram powers up unknown
  dmb_row_t rows [19] = '{
    '{OP_LOAD_BANK, 16'h0001, 0, 0, 8'h00, 12'h000, 0, 8'h00, 0, 8'h01},
    '{OP_FILE,      16'h0010, 1, 1, 8'h5a, 12'h110, 0, 8'h00, 0, 8'h01},
    '{OP_FILE,      16'h0010, 1, 0, 8'h00, 12'h110, 0, 8'h5a, 1, 8'h01},
    '{OP_FILE,      16'h0010, 0, 1, 8'h33, 12'h010, 0, 8'h00, 0, 8'h01},
    '{OP_FILE,      16'h0010, 0, 0, 8'h00, 12'h010, 0, 8'h33, 1, 8'h01},
    '{OP_FILE,      16'h005f, 0, 1, 8'h44, 12'h05f, 0, 8'h00, 0, 8'h01},
    '{OP_FILE,      16'h0060, 0, 1, 8'h66, 12'hf60, 0, 8'h00, 0, 8'h01},
    '{OP_FILE,      16'h0060, 0, 0, 8'h00, 12'hf60, 0, 8'h66, 1, 8'h01},
    '{OP_FILE,      16'h005f, 0, 0, 8'h00, 12'h05f, 0, 8'h44, 1, 8'h01},
    '{OP_LOAD_BANK, 16'h00ab, 0, 0, 8'h00, 12'h000, 0, 8'h00, 0, 8'h0b},
    '{OP_FILE,      16'h0020, 1, 1, 8'h77, 12'hb20, 1, 8'h00, 0, 8'h0b},
    '{OP_FILE,      16'h0020, 1, 0, 8'h00, 12'hb20, 1, 8'h00, 1, 8'h0b},
    '{OP_LOAD_BANK, 16'h0003, 0, 0, 8'h00, 12'h000, 0, 8'h00, 0, 8'h03},
    '{OP_FILE,      16'h00ff, 1, 0, 8'h00, 12'h3ff, 1, 8'h00, 1, 8'h03},
    '{OP_FILE,      16'h00e0, 0, 1, 8'ha5, 12'hfe0, 0, 8'h00, 0, 8'h05},
    '{OP_LOAD_BANK, 16'h000f, 0, 0, 8'h00, 12'h000, 0, 8'h00, 0, 8'h0f},
    '{OP_FILE,      16'h00f9, 1, 1, 8'h3c, 12'hff9, 0, 8'h00, 0, 8'h0f},
    '{OP_WORD2,     16'hf456, 0, 0, 8'h00, 12'h000, 0, 8'h00, 0, 8'h0f},
    '{OP_NONE,      16'h0000, 0, 0, 8'h00, 12'h000, 0, 8'h00, 0, 8'h0f}
  };
  // ************************************************************
  // design, core model and clock
  // ************************************************************
  dmb_core_model i_dmb_core_model (.clk(clk), .sys_rst(sys_rst), .phase(phase),
    .next_op(next_op), .next_word(next_word), .next_a(next_a), .next_dw(next_dw),
    .next_res(next_res), .instr_op(instr_op), .instr_word(instr_word),
    .access_sel(access_sel), .dest_write(dest_write), .result_data(result_data));
  dmb_data_addr i_dmb_data_addr (.clk(clk), .sys_rst(sys_rst), .instr_op(instr_op),
    .instr_word(instr_word), .access_sel(access_sel), .dest_write(dest_write),
    .result_data(result_data), .extended_set_enable(extended_set_enable),
    .index_base(index_base), .phase(phase), .data_addr(data_addr),
    .addr_absent(addr_absent), .operand_data(operand_data),
    .status_update(status_update), .bank_pointer(bank_pointer),
    .pc_low_write(pc_low_write), .pc_low_data(pc_low_data), .word2_nop(word2_nop));
  // 20 mhz quarter-cycle clock, four per 5 mhz instruction cycle
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ************************************************************
  // bench tasks
  // ************************************************************
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // step n edges, then let that edge's updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // queue one instruction; returns on the q4 edge that loads it
  task automatic issue(input dmb_op_t op, input logic [15:0] w, input logic a, dw,
                       input logic [7:0] res);
    int k;
    @(posedge clk);
    next_op <= op;
    next_word <= w;
    next_a <= a;
    next_dw <= dw;
    next_res <= res;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      if (phase === PH_Q4) break;
    end
    if (k == 8) begin
      err_total++;
      wrap_up();
    end
    next_op <= OP_NONE;
  endtask : issue
  task automatic chk_rst();
    `CHK(phase, PH_Q1)
    `CHK(data_addr, ADDR_NONE)
    `CHK(operand_data, ZERO_BYTE)
    `CHK(bank_pointer, BANK_PTR_RESET)
    `CHK(pc_low_data, ZERO_BYTE)
  endtask : chk_rst
  // one lone instruction, checked quarter by quarter
  task automatic step(input dmb_row_t r);
    issue(r.op, r.w, r.a, r.dw, r.res);
    tick(1);
    `CHK(data_addr, r.addr)
    `CHK(addr_absent, r.absent)
    `CHK(word2_nop, r.op == OP_WORD2)
    tick(1);
    if (r.chk) `CHK(operand_data, r.rd)
    tick(2);
    `CHK(status_update, r.op == OP_FILE)
    `CHK(bank_pointer, r.bp)
    `CHK(pc_low_write, r.op == OP_FILE && r.dw && r.addr == PCL_ADDR)
    if (r.addr == PCL_ADDR) `CHK(pc_low_data, r.res)
  endtask : step
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    sys_rst = 1'b1;
    extended_set_enable = 1'b0;
    index_base = 12'h000;
    next_op = OP_NONE;
    next_word = 16'h0000;
    next_a = 1'b0;
    next_dw = 1'b0;
    next_res = 8'h00;
    repeat (11) @(posedge clk);
    #1;
    chk_rst();
    @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) step(rows[i]);
    // full-address move pair, bank pointer sits at 0fh and must not matter
    issue(OP_MOVE_FULL, 16'h0110, 1'b1, 1'b0, 8'h00);
    tick(1);
    `CHK(data_addr, 12'h110)
    tick(1);
    `CHK(operand_data, 8'h5a)
    issue(OP_WORD2, 16'hf011, 1'b0, 1'b0, 8'h00);
    tick(1);
    `CHK(data_addr, 12'h011)
    `CHK(word2_nop, 1'b0)
    tick(3);
    `CHK(status_update, 1'b0)
    step('{OP_FILE, 16'h0011, 0, 0, 8'h00, 12'h011, 0, 8'h5a, 1, 8'h0f});
    // extended map moves only the low part of the access bank
    @(posedge clk);
    extended_set_enable <= 1'b1;
    index_base <= 12'h200;
    step('{OP_FILE, 16'h0005, 0, 1, 8'h9e, 12'h205, 0, 8'h00, 0, 8'h0f});
    step('{OP_FILE, 16'h0005, 0, 0, 8'h00, 12'h205, 0, 8'h9e, 1, 8'h0f});
    step('{OP_FILE, 16'h0060, 0, 0, 8'h00, 12'hf60, 0, 8'h66, 1, 8'h0f});
    @(posedge clk);
    extended_set_enable <= 1'b0;
    // reset in mid-run clears the pointer but keeps ram contents
    @(posedge clk);
    sys_rst <= 1'b1;
    tick(2);
    chk_rst();
    @(posedge clk);
    sys_rst <= 1'b0;
    step('{OP_FILE, 16'h0010, 0, 0, 8'h00, 12'h010, 0, 8'h33, 1, 8'h00});
    wrap_up();
  end
endmodule : dmb_data_addr_tb_top
`default_nettype wire
